//--- core/sbic_core.sv
// pin-control, version-request and clear command handling of a bus slave
// assumes commands arrive CRC-checked as one-cycle pulses from the framer
// assumes hclk is the only clock and every input is synchronous to it
// assumes software writes the device address before any addressed command
// Behaviour
// RULE1 - a pin whose direction bit is 1 is driven with its commanded level.
// RULE2 - a pin whose direction bit is 0 is an input and its level bit has no effect.
// RULE3 - the pin-control data byte holds three level and three direction bits, one per pin.
// RULE4 - reset and clear set all direction bits to 0, making every pin an input.
// RULE5 - a valid addressed pin-control command is answered in the next message.
// RULE6 - pin-control and version commands count only in long-word frames, never short.
// RULE7 - the pin-control reply echoes direction and commanded level, not the pins.
// RULE8 - pin-control and version commands act only when the address matches.
// RULE9 - a pin-control command to address 0000 is applied by all with no reply.
// RULE10 - a version request returns a four-bit version and the fuse-parity error bit.
// RULE11 - at power-up the fuse parity is computed and compared with the stored one.
// RULE12 - a version request to address 0000 is ignored entirely.
// RULE13 - an accepted clear opens the bus switch and returns registers to reset values; the code keeps the interrupt mask and sets interrupt status bit 2.
// RULE14 - a clear command is never answered.
// RULE15 - clear is accepted for the own address and for address 0000.
// RULE16 - codes are pin control 3, version 4, clear 7; clear is valid in every frame.
// RULE17 - pin levels for status are latched on request and held until the reply.
`timescale 1ns/1ns
module sbic_core #(
    parameter logic [3:0] SILICON_VERSION = 4'h2, // arbitrary value
    parameter int FUSE_BITS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cmd_valid,
    input wire sbic_pkg::sbic_cmd_t cmd_in,
    input wire logic status_req,
    input wire logic reply_sent,
    output logic reply_valid,
    output logic [15:0] reply_word,
    output logic bus_switch_open,
    input wire logic [FUSE_BITS-1:0] fuse_bits,
    input wire logic fuse_parity_stored,
    input wire logic [2:0] logic_pin_in,
    output logic [2:0] logic_pin_out,
    output logic [2:0] logic_pin_oe,
    output logic [2:0] pin_status_latched,
    output logic irq
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // refuse a fuse vector the parity tree cannot take
    initial
    begin
        if (FUSE_BITS < 1)
        begin
            $error("FUSE_BITS must be at least 1");
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // command-side state
    logic [3:0] dev_addr_ff;
    logic [2:0] pin_direction_bits_ff;
    logic [2:0] pin_drive_level_ff;
    logic fuse_parity_error_ff;
    logic parity_done_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    // decoded command strobes, one cycle each
    logic is_long;
    logic addr_match;
    logic addr_global;
    logic do_pin;
    logic do_pin_reply;
    logic do_ver;
    logic do_clear;

    // frame kind and address compare
    // RULE6 long-word only
    assign is_long = (cmd_in.frame == sbic_pkg::SBIC_FRM_LONG);
    assign addr_match = (cmd_in.addr == dev_addr_ff);
    assign addr_global = (cmd_in.addr == sbic_pkg::ADDR_GLOBAL);
    // RULE16 command codes
    // RULE8 own address
    // RULE9 global applies
    assign do_pin = cmd_valid && is_long && (cmd_in.cmd == sbic_pkg::CMD_PIN_CTRL)
        && (addr_match || addr_global);
    // global pin control is applied but never answered
    assign do_pin_reply = do_pin && !addr_global;
    // RULE12 global ignored
    assign do_ver = cmd_valid && is_long && (cmd_in.cmd == sbic_pkg::CMD_VERSION)
        && addr_match && !addr_global;
    // RULE15 own or global
    assign do_clear = cmd_valid && (cmd_in.cmd == sbic_pkg::CMD_CLEAR)
        && (addr_match || addr_global);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // write address held into the data phase
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] nxt_rdata;
    logic take;

    // hsize is not decoded, whole-word transfers only
    assign take = hsel && hready && htrans[1];

    // address phase capture, zero wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= take && hwrite;
            wr_addr_ff <= take ? haddr[7:0] : wr_addr_ff;
        end
    end

    // read mux, unmapped reads as zero
    // only the low address byte is decoded
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        case (haddr[7:0])
            sbic_pkg::OFS_ADDR: nxt_rdata[3:0] = dev_addr_ff;
            sbic_pkg::OFS_PINS: nxt_rdata[10:0] = {logic_pin_in, 1'b0, pin_drive_level_ff,
                1'b0, pin_direction_bits_ff};
            sbic_pkg::OFS_IRQ_STAT: nxt_rdata[2:0] = irq_stat_ff;
            sbic_pkg::OFS_IRQ_MASK: nxt_rdata[2:0] = irq_mask_ff;
            sbic_pkg::OFS_FUSE: nxt_rdata[0] = fuse_parity_error_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // read data registered, always ready, always okay
    // hrdata holds between reads so a late sample stays valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hrdata <= (take && !hwrite) ? nxt_rdata : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // device address (set by initialization elsewhere, via software)
    // ----------------------------------------------------------------
    // clear drops the address, software must set it again
    // RULE13 clear resets registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dev_addr_ff <= sbic_pkg::RST_ADDR;
        end
        else if (do_clear)
        begin
            dev_addr_ff <= sbic_pkg::RST_ADDR;
        end
        else if (wr_pend_ff && wr_addr_ff == sbic_pkg::OFS_ADDR)
        begin
            dev_addr_ff <= hwdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // pin control
    // ----------------------------------------------------------------
    // RULE3 field extraction
    // clear wins over a pin command in the same cycle
    // RULE4 reset and clear inputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_direction_bits_ff <= sbic_pkg::RST_DIR;
            pin_drive_level_ff <= sbic_pkg::RST_LVL;
        end
        else if (do_clear)
        begin
            pin_direction_bits_ff <= sbic_pkg::RST_DIR;
            pin_drive_level_ff <= sbic_pkg::RST_LVL;
        end
        else if (do_pin)
        begin
            pin_direction_bits_ff <= cmd_in.data[sbic_pkg::DIR_LSB +: sbic_pkg::PIN_COUNT];
            pin_drive_level_ff <= cmd_in.data[sbic_pkg::LVL_LSB +: sbic_pkg::PIN_COUNT];
        end
    end

    // per-pin driver, output only when direction is 1
    // pin count is fixed at three by the data byte layout
    // each pin is one flip-flop pair: enable and level
    genvar gi;
    generate
        for (gi = 0; gi < sbic_pkg::PIN_COUNT; gi++)
        begin : g_pin
            // outputs lag the direction and level registers by one cycle
            // an input pin is never driven, whatever its level bit says
            // RULE1 drive output
            // RULE2 input ignores level
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    logic_pin_oe[gi] <= 1'b0;
                    logic_pin_out[gi] <= 1'b0;
                end
                else
                begin
                    logic_pin_oe[gi] <= pin_direction_bits_ff[gi];
                    logic_pin_out[gi] <= pin_direction_bits_ff[gi] & pin_drive_level_ff[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin status latch
    // ----------------------------------------------------------------
    // RULE17 latch and hold
    // the first request latches, later requests are ignored until the reply
    logic status_hold_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_hold_ff <= 1'b0;
            pin_status_latched <= 3'h0;
        end
        // RULE13 clear releases the latch
        else if (do_clear)
        begin
            status_hold_ff <= 1'b0;
            pin_status_latched <= 3'h0;
        end
        else if (status_req && !status_hold_ff)
        begin
            status_hold_ff <= 1'b1;
            pin_status_latched <= logic_pin_in;
        end
        else if (reply_sent)
        begin
            status_hold_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // fuse parity check after reset release
    // ----------------------------------------------------------------
    // evaluated once, the fuses are taken as stable after reset
    // a mismatch stays flagged until the next reset
    // RULE11 parity compare
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            parity_done_ff <= 1'b0;
            fuse_parity_error_ff <= 1'b0;
        end
        else if (!parity_done_ff)
        begin
            parity_done_ff <= 1'b1;
            fuse_parity_error_ff <= (^fuse_bits) != fuse_parity_stored;
        end
    end

    // ----------------------------------------------------------------
    // reply for the next message
    // ----------------------------------------------------------------
    // RULE5 reply next message
    // RULE7 echo commanded bits
    // RULE10 version and parity
    // RULE14 clear silent
    // a clear drops a pending reply and starts none
    // a newer reply overrides an unsent one
    // reply layouts: address, zeros, then the payload
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reply_valid <= 1'b0;
            reply_word <= 16'h0000;
        end
        else if (do_clear)
        begin
            reply_valid <= 1'b0;
            reply_word <= 16'h0000;
        end
        else if (do_pin_reply)
        begin
            reply_valid <= 1'b1;
            reply_word <= {cmd_in.addr, 5'h00, cmd_in.data[6:4], 1'b0, cmd_in.data[2:0]};
        end
        else if (do_ver)
        begin
            reply_valid <= 1'b1;
            reply_word <= {cmd_in.addr, 4'h0, SILICON_VERSION, 3'h0, fuse_parity_error_ff};
        end
        else if (reply_sent)
        begin
            reply_valid <= 1'b0;
        end
    end

    // software closes the switch, clear and reset open it
    // RULE13 open bus switch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_switch_open <= 1'b1;
        end
        else if (do_clear)
        begin
            bus_switch_open <= 1'b1;
        end
        else if (wr_pend_ff && wr_addr_ff == sbic_pkg::OFS_FUSE)
        begin
            bus_switch_open <= hwdata[8];
        end
    end

    // ----------------------------------------------------------------
    // interrupts: set wins over write-one-to-clear
    // ----------------------------------------------------------------
    // event strobes in status bit order
    logic [2:0] ev;
    // write-one-to-clear strobe, live only in a write data phase
    logic [2:0] w1c;
    assign ev = {do_clear, do_ver, do_pin};
    assign w1c = (wr_pend_ff && wr_addr_ff == sbic_pkg::OFS_IRQ_STAT) ? hwdata[2:0] : 3'h0;

    // status, mask and the registered interrupt line
    // an event in the clearing cycle keeps its bit set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_ff <= sbic_pkg::RST_IRQ;
            irq_mask_ff <= sbic_pkg::RST_IRQ;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
            if (wr_pend_ff && wr_addr_ff == sbic_pkg::OFS_IRQ_MASK)
            begin
                irq_mask_ff <= hwdata[2:0];
            end
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule : sbic_core

//--- pkg/sbic_pkg.sv
// package for the sensor-bus pin-control, version and clear command block
// assumes the frame decoder delivers checked commands as one-cycle pulses
package sbic_pkg;

    // ----------------------------------------------------------------
    // command codes and frame kinds
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_PIN_CTRL = 4'h3;
    localparam logic [3:0] CMD_VERSION = 4'h4;
    localparam logic [3:0] CMD_CLEAR = 4'h7;
    localparam logic [3:0] ADDR_GLOBAL = 4'h0;

    typedef enum logic [1:0] {
        SBIC_FRM_LONG,
        SBIC_FRM_SHORT8,
        SBIC_FRM_SHORT10
    } sbic_frame_t;

    // command as handed over by the frame decoder
    typedef struct packed {
        sbic_frame_t frame;
        logic [7:0] data;
        logic [3:0] addr;
        logic [3:0] cmd;
    } sbic_cmd_t;

    // ----------------------------------------------------------------
    // data byte field positions
    // ----------------------------------------------------------------
    localparam int DIR_LSB = 0;
    localparam int LVL_LSB = 4;
    localparam int PIN_COUNT = 3;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_PINS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_FUSE = 8'h10;

    // interrupt status bits
    localparam int IRQ_PIN_CTRL = 0;
    localparam int IRQ_VERSION = 1;
    localparam int IRQ_CLEAR = 2;
    localparam int IRQ_COUNT = 3;

    // reset values
    localparam logic [3:0] RST_ADDR = 4'h0;
    localparam logic [2:0] RST_DIR = 3'h0;
    localparam logic [2:0] RST_LVL = 3'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;

endpackage : sbic_pkg

//--- dv/sbic_chk.sv
// checker for the command block port behaviour
// bound onto sbic_core, sees its ports only
`timescale 1ns/1ns
module sbic_chk #(
    parameter logic [3:0] SILICON_VERSION = 4'h2,
    parameter int FUSE_BITS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cmd_valid,
    input wire sbic_pkg::sbic_cmd_t cmd_in,
    input wire logic reply_sent,
    input wire logic reply_valid,
    input wire logic [15:0] reply_word,
    input wire logic bus_switch_open,
    input wire logic [FUSE_BITS-1:0] fuse_bits,
    input wire logic fuse_parity_stored,
    input wire logic [2:0] logic_pin_out,
    input wire logic [2:0] logic_pin_oe
);
    // --------------------
    // helpers
    // --------------------
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic fpe;
    // expected fuse flag
    assign fpe = (^fuse_bits) ^ fuse_parity_stored;
    sequence s_pin_ok;
        cmd_valid && cmd_in.cmd == sbic_pkg::CMD_PIN_CTRL && !reply_valid ##1 reply_valid;
    endsequence
    sequence s_ver_ok;
        cmd_valid && cmd_in.cmd == sbic_pkg::CMD_VERSION && !reply_valid ##1 reply_valid;
    endsequence
    // --------------------
    // assertions
    // --------------------
    // reply echo
    chk_pin_echo: assert property (
        s_pin_ok |-> reply_word == {$past(cmd_in.addr), 5'h00, $past(cmd_in.data[6:4]),
        1'b0, $past(cmd_in.data[2:0])}) else $error("pin reply wrong");
    chk_pin_drive: assert property (
        s_pin_ok |-> ##2 logic_pin_oe == $past(cmd_in.data[2:0], 3) && (logic_pin_out &
        logic_pin_oe) == ($past(cmd_in.data[6:4], 3) & logic_pin_oe)) else $error("pin drive");
    chk_ver_word: assert property (
        s_ver_ok |-> reply_word == {$past(cmd_in.addr), 4'h0, SILICON_VERSION, 3'h0, fpe})
        else $error("version reply wrong");
    chk_short_quiet: assert property (
        cmd_valid && cmd_in.frame != sbic_pkg::SBIC_FRM_LONG && !reply_valid |=> !reply_valid)
        else $error("short frame answered");
    chk_global_quiet: assert property (
        cmd_valid && cmd_in.addr == sbic_pkg::ADDR_GLOBAL && !reply_valid |=> !reply_valid)
        else $error("global answered");
    chk_clear_open: assert property (
        cmd_valid && cmd_in.cmd == sbic_pkg::CMD_CLEAR && cmd_in.addr == sbic_pkg::ADDR_GLOBAL
        |-> ##3 bus_switch_open && !reply_valid && logic_pin_oe == 3'h0) else $error("clear");
    chk_oe_steady: assert property (
        !$stable(logic_pin_oe) |-> $past(cmd_valid) || $past(cmd_valid, 2) || $past(cmd_valid, 3))
        else $error("direction moved");
    chk_reply_hold: assert property (
        reply_valid && !reply_sent && !cmd_valid && !$past(cmd_valid) |=> reply_valid &&
        $stable(reply_word)) else $error("reply not held");
endmodule : sbic_chk
bind sbic_core sbic_chk #(.SILICON_VERSION(SILICON_VERSION), .FUSE_BITS(FUSE_BITS)) sbic_chk_i (
    .hclk, .hresetn, .cmd_valid, .cmd_in, .reply_sent, .reply_valid, .reply_word,
    .bus_switch_open, .fuse_bits, .fuse_parity_stored, .logic_pin_out, .logic_pin_oe);

//--- dv/sbic_master_model.sv
// master-side model: issues checked commands and the outside pin levels
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ns
module sbic_master_model (
    input wire logic hclk,
    output sbic_pkg::sbic_cmd_t cmd_in,
    output logic cmd_valid,
    output logic reply_sent,
    output logic status_req,
    input wire logic [2:0] logic_pin_out,
    input wire logic [2:0] logic_pin_oe,
    output logic [2:0] logic_pin_in
);
    logic [2:0] ext_lvl;
    // idle levels at time zero
    initial
    begin
        cmd_in = '0;
        cmd_valid = 1'b0;
        reply_sent = 1'b0;
        status_req = 1'b0;
        ext_lvl = 3'h5;
    end
    // pin wire: device drive wins, else outside level
    assign logic_pin_in = (logic_pin_oe & logic_pin_out) | (~logic_pin_oe & ext_lvl);
    task send(input sbic_pkg::sbic_frame_t f, input logic [3:0] a, input logic [3:0] c,
        input logic [7:0] d);
        cmd_in <= '{frame: f, data: d, addr: a, cmd: c};
        cmd_valid <= 1'b1;
        @(posedge hclk);
        cmd_valid <= 1'b0;
        cmd_in <= sbic_pkg::sbic_cmd_t'(~cmd_in);
    endtask : send
    // one-cycle reply-done or status pulse
    task ack(input logic st);
        status_req <= st;
        reply_sent <= !st;
        @(posedge hclk);
        status_req <= 1'b0;
        reply_sent <= 1'b0;
    endtask : ack
endmodule : sbic_master_model

//--- dv/testbench.sv
// self-checking bench: a rule model compared at every result
// assumes core, checker bind and master model compiled first
`timescale 1ns/1ns
module testbench;
    // --------------------
    // signals, model state
    // --------------------
    localparam logic [3:0] VER = 4'hC; // arbitrary value
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hsel = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, v;
    logic hreadyout, hresp, cmd_valid, status_req, reply_sent, reply_valid, bus_switch_open, irq;
    sbic_pkg::sbic_cmd_t cmd_in;
    logic [15:0] reply_word, m_rw, fuse_bits;
    logic fuse_parity_stored = 1'b1;
    logic [2:0] logic_pin_in, logic_pin_out, logic_pin_oe, pin_status_latched, e;
    logic [2:0] m_dir = 3'h0;
    logic [2:0] m_lvl = 3'h0;
    logic [3:0] m_addr = 4'h0;
    logic m_rv = 1'b0;
    logic m_bso = 1'b1;
    logic m_fpe;
    int fails = 0;
    int tests_run = 0;
    int seed = 29;
    int k;
    // 8 ns clock
    always #4 hclk = ~hclk;
    sbic_core #(.SILICON_VERSION(VER)) sbic_core_i (.hclk, .hresetn, .haddr, .htrans, .hwrite,
        .hsize, .hsel, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cmd_valid,
        .cmd_in, .status_req, .reply_sent, .reply_valid, .reply_word, .bus_switch_open,
        .fuse_bits, .fuse_parity_stored, .logic_pin_in, .logic_pin_out, .logic_pin_oe,
        .pin_status_latched, .irq);
    sbic_master_model sbic_master_model_i (.hclk, .cmd_in, .cmd_valid, .reply_sent,
        .status_req, .logic_pin_out, .logic_pin_oe, .logic_pin_in);
    // --------------------
    // tasks
    // --------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // one single bus transfer
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask : ahb
    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask : rd_chk
    // compare design against model
    task cmp;
        repeat (4) @(posedge hclk);
        check(reply_valid, m_rv);
        if (m_rv)
            check(reply_word, m_rw);
        check(logic_pin_oe, m_dir);
        check(logic_pin_out & logic_pin_oe, m_lvl & m_dir);
        check(bus_switch_open, m_bso);
        ahb(1'b0, 32'h4, 32'h0, v);
        check(v[6:0], {m_lvl, 1'b0, m_dir});
    endtask : cmp
    // send one command, update model, compare
    task cmd(input sbic_pkg::sbic_frame_t f, input logic [3:0] a, input logic [3:0] c,
        input logic [7:0] d, input logic fin);
        logic hit;
        hit = (a == m_addr) || (a == sbic_pkg::ADDR_GLOBAL);
        sbic_master_model_i.send(f, a, c, d);
        if (c == sbic_pkg::CMD_CLEAR && hit)
        begin
            {m_dir, m_lvl, m_addr, m_bso, m_rv} = {10'h0, 1'b1, 1'b0};
        end
        else if (f == sbic_pkg::SBIC_FRM_LONG && hit && c == sbic_pkg::CMD_PIN_CTRL)
        begin
            {m_lvl, m_dir} = {d[6:4], d[2:0]};
            m_rv = m_rv | (a != 4'h0);
            m_rw = {a, 5'h00, d[6:4], 1'b0, d[2:0]};
        end
        else if (f == sbic_pkg::SBIC_FRM_LONG && c == sbic_pkg::CMD_VERSION && a == m_addr && hit
            && a != 4'h0)
        begin
            m_rv = 1'b1;
            m_rw = {a, 4'h0, VER, 3'h0, m_fpe};
        end
        cmp();
        if (fin && m_rv)
        begin
            sbic_master_model_i.ack(1'b0);
            m_rv = 1'b0;
            @(posedge hclk);
            check(reply_valid, m_rv);
        end
    endtask : cmd
    // own address, closed switch
    task setup;
        m_addr = 4'($random(seed));
        m_addr[3] = 1'b1;
        ahb(1'b1, 32'h0, {28'h0, m_addr}, v);
        ahb(1'b1, 32'h10, 32'h0, v);
        m_bso = 1'b0;
        repeat (2) @(posedge hclk);
        check(bus_switch_open, m_bso);
    endtask : setup
    task report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // watchdog
    initial
    begin
        #200000;
        fails++;
        report_and_stop();
    end
    // --------------------
    // main sequence
    // --------------------
    initial
    begin
        fuse_bits = 16'($random(seed));
        m_fpe = (^fuse_bits) ^ fuse_parity_stored;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(32'h10, {31'h0, m_fpe});
        rd_chk(32'h20, 32'h0);
        cmp();
        setup();
        for (int i = 0; i < 20; i++)
        begin
            k = i % 5;
            cmd((k == 3) ? (i[0] ? sbic_pkg::SBIC_FRM_SHORT8 : sbic_pkg::SBIC_FRM_SHORT10) :
                sbic_pkg::SBIC_FRM_LONG, (k == 4) ? 4'h0 : (k == 2) ? m_addr ^ 4'h1 : m_addr,
                (i < 10) ? sbic_pkg::CMD_PIN_CTRL : sbic_pkg::CMD_VERSION, 8'($random(seed)),
                1'b1);
        end
        e = (m_dir & m_lvl) | (~m_dir & 3'h5);
        sbic_master_model_i.ack(1'b1);
        sbic_master_model_i.ext_lvl <= 3'h2;
        @(posedge hclk);
        sbic_master_model_i.ack(1'b1);
        repeat (2) @(posedge hclk);
        check(pin_status_latched, e);
        ahb(1'b0, 32'h4, 32'h0, v);
        check(v[10:8], (m_dir & m_lvl) | (~m_dir & 3'h2));
        // event flag, mask, clear
        ahb(1'b1, 32'h8, 32'h7, v);
        ahb(1'b1, 32'hC, 32'h1, v);
        cmd(sbic_pkg::SBIC_FRM_LONG, m_addr, sbic_pkg::CMD_PIN_CTRL, 8'h65, 1'b1);
        check(irq, 1'b1);
        rd_chk(32'h8, 32'h1);
        ahb(1'b1, 32'hC, 32'h0, v);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        ahb(1'b1, 32'hC, 32'h1, v);
        ahb(1'b1, 32'h8, 32'h1, v);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        cmd(sbic_pkg::SBIC_FRM_LONG, m_addr ^ 4'h1, sbic_pkg::CMD_CLEAR, 8'h00, 1'b1);
        cmd(sbic_pkg::SBIC_FRM_LONG, m_addr, sbic_pkg::CMD_PIN_CTRL, 8'h77, 1'b0);
        cmd(sbic_pkg::SBIC_FRM_SHORT8, m_addr, sbic_pkg::CMD_CLEAR, 8'h00, 1'b1);
        rd_chk(32'h0, 32'h0);
        setup();
        cmd(sbic_pkg::SBIC_FRM_LONG, m_addr, sbic_pkg::CMD_PIN_CTRL, 8'h37, 1'b1);
        cmd(sbic_pkg::SBIC_FRM_SHORT10, 4'h0, sbic_pkg::CMD_CLEAR, 8'hFF, 1'b1);
        report_and_stop();
    end
endmodule : testbench
